// *** hw/dscj_ctrl.v ***
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module dscj_ctrl
(
  // clock and reset
  input  wire        i_clock,
  input  wire        i_resetn,
  // software register port
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  // device pins
  input  wire        i_vblank,
  output reg  [7:0]  o_dev_addr,
  output reg  [31:0] o_dev_wdata,
  output reg         o_dev_wr
);
`include "dscj_defs.vh"

  localparam S_IDLE  = 3'h0;
  localparam S_GO    = 3'h1;
  localparam S_WAIT  = 3'h2;
  localparam S_EVAL  = 3'h3;
  localparam S_VB    = 3'h4;
  localparam S_WRITE = 3'h5;

  reg  [11:0] ctrl_r;
  reg  [15:0] hact_r;
  reg  [15:0] vact_r;
  reg  [15:0] slice_w_r;
  reg  [15:0] slice_h_r;
  reg  [15:0] overlap_r;
  reg  [3:0]  slices_r;
  reg  [5:0]  bpp_r;
  reg  [12:0] pixclk_r;
  reg  [12:0] cdclk_r;
  reg  [12:0] portclk_r;
  reg  [5:0]  link_r;
  reg  [2:0]  state_r;
  reg  [2:0]  step_r;
  reg  [2:0]  widx_r;
  reg         busy_r;
  reg         done_r;
  reg  [7:0]  err_r;
  reg  [11:0] rows_r;
  reg  [5:0]  lim_link_r;
  reg  [5:0]  lim_thru_r;
  reg  [5:0]  lim_bj_r;
  reg  [5:0]  lim_ram_r;
  reg  [5:0]  max_bpp_r;
  reg         div_start_r;
  reg         vb_s1_r;
  reg         vb_s2_r;
  reg         vb_prev_r;
  reg  [47:0] div_num;
  reg  [47:0] div_den;
  reg  [7:0]  err_nxt;
  reg  [5:0]  lim_min;
  wire        div_done;
  wire [47:0] div_quot;
  wire [47:0] div_rem;

  wire        split   = ctrl_r[`DSCJ_CTRL_SPLIT];
  wire        join_en = ctrl_r[`DSCJ_CTRL_JOIN];
  wire        big     = ctrl_r[`DSCJ_CTRL_BIG];
  wire        comp    = ctrl_r[`DSCJ_CTRL_COMP];
  wire        multi_segment_operation = ctrl_r[`DSCJ_CTRL_MULTI_SEG];
  wire [1:0]  mode    = ctrl_r[`DSCJ_CTRL_MODE_LO+1:`DSCJ_CTRL_MODE_LO];
  wire [2:0]  lanes   = link_r[2:0];
  wire [1:0]  ppc     = link_r[5:4];
  wire [3:0]  br_slices = split ? {1'b0, slices_r[3:1]} : slices_r;
  // overlap pixels counted in the width
  wire [15:0] hwidth  = multi_segment_operation ? hact_r + overlap_r : hact_r;
  wire [15:0] pic_w   = (split ? {1'b0, hact_r[15:1]} : hact_r) + (multi_segment_operation ? overlap_r : 16'h0);
  wire [47:0] scale   = ctrl_r[`DSCJ_CTRL_FEC] ? `DSCJ_FEC_SCALE : `DSCJ_ONE_SCALE;
  wire [47:0] pix_den = {35'h0, pixclk_r} * `DSCJ_ONE_SCALE;
  wire [15:0] pipe_bw = {14'h0, ppc} * {3'h0, cdclk_r} * (big ? 16'h2 : 16'h1);

  function [5:0] sat6;
    input [47:0] q;
    begin
      sat6 = (q > 48'h3f) ? 6'h3f : q[5:0];
    end
  endfunction

  // device register image for write slot n
  function [39:0] dev_word;
    input [2:0] n;
    reg   [7:0] base;
    begin
      base = n[2] ? `DSCJ_DEV_BR1 : `DSCJ_DEV_BR0;
      case (n)
        // joined stream on upper/left; link map
        3'h0:    dev_word = {`DSCJ_DEV_SJ_CTL, 23'h0, ctrl_r[`DSCJ_CTRL_SYNC], mode, 1'b1,
                             join_en, comp, big, join_en, split};
        3'h1,
        3'h4:    dev_word = {base + `DSCJ_DEV_SLICES, 4'h0, rows_r, 12'h0, br_slices};
        3'h2,
        3'h5:    dev_word = {base + `DSCJ_DEV_PIC, vact_r, pic_w};
        // parameter set states full frame width
        3'h3,
        3'h6:    dev_word = {base + `DSCJ_DEV_PPS, 10'h0, bpp_r, hwidth};
        default: dev_word = 40'h0;
      endcase
    end
  endfunction

  // image of the word in the current write slot
  wire [39:0] dev_cur = dev_word(widx_r);

  // pin synchroniser
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      vb_s1_r   <= 1'b0;
      vb_s2_r   <= 1'b0;
      vb_prev_r <= 1'b0;
    end
    else
    begin
      vb_s1_r   <= i_vblank;
      vb_s2_r   <= vb_s1_r;
      vb_prev_r <= vb_s2_r;
    end
  end

  // divider operand selection per step
  always @*
  begin
    div_num = 48'h0;
    div_den = pix_den;
    case (step_r)
      3'h0:
      begin
        div_num = {32'h0, hwidth};
        div_den = {32'h0, slice_w_r};
      end
      3'h1:
      begin
        div_num = {32'h0, vact_r};
        div_den = {32'h0, slice_h_r};
      end
      // strict bound, hence the minus one
      3'h2: div_num = {45'h0, lanes} * {35'h0, portclk_r} * `DSCJ_LANE_BITS * scale - 48'h1;
      3'h3: div_num = {35'h0, portclk_r} * `DSCJ_THRU_BITS * scale - 48'h1;
      3'h4: div_num = {46'h0, ppc} * {35'h0, cdclk_r} * `DSCJ_BJ_BITS * scale;
      3'h5:
      begin
        div_num = (big ? `DSCJ_RAM_TWO : `DSCJ_RAM_ONE) * 48'h8;
        div_den = {32'h0, hwidth};
      end
      default: div_num = 48'h0;
    endcase
  end

  // static configuration faults
  always @*
  begin
    err_nxt = 8'h0;
    // one or two slices per branch, even split
    if ((br_slices != 4'h1 && br_slices != 4'h2) || (split && slices_r[0]))
      err_nxt[0] = 1'b1;
    // joiner needs both branches, two or four slices
    if (join_en && (!split || (slices_r != 4'h2 && slices_r != 4'h4)))
      err_nxt[0] = 1'b1;
    // big joiner four or eight, otherwise at most four
    if (big ? (slices_r != 4'h4 && slices_r != 4'h8) : (slices_r > 4'h4))
      err_nxt[0] = 1'b1;
    // big joiner needs small joiner and compression
    if (big && (!join_en || !comp))
      err_nxt[1] = 1'b1;
    if (hact_r > (big ? `DSCJ_MAX_W_TWO : `DSCJ_MAX_W_ONE) || hact_r == 16'h0)
      err_nxt[4] = 1'b1;
    if ({3'h0, pixclk_r} >= pipe_bw)
      err_nxt[5] = 1'b1;
    if (mode == `DSCJ_MODE_DUAL &&
        (!split || join_en || ctrl_r[`DSCJ_CTRL_PIPE] || !ctrl_r[`DSCJ_CTRL_SYNC]))
      err_nxt[7] = 1'b1;
    // independent links need this pipe's joined pair
    if (mode == `DSCJ_MODE_DUAL_IND && (!split || !join_en))
      err_nxt[7] = 1'b1;
  end

  always @*
  begin
    lim_min = lim_link_r;
    if (lim_thru_r < lim_min)
      lim_min = lim_thru_r;
    if (big && lim_bj_r < lim_min)
      lim_min = lim_bj_r;
    if (lim_ram_r < lim_min)
      lim_min = lim_ram_r;
    if (lim_min > `DSCJ_BPP_MAX)
      lim_min = `DSCJ_BPP_MAX;
  end

  // software registers and sequencer
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctrl_r      <= `DSCJ_CTRL_RESET;
      hact_r      <= 16'h0;
      vact_r      <= 16'h0;
      slice_w_r   <= 16'h0;
      slice_h_r   <= 16'h0;
      overlap_r   <= 16'h0;
      slices_r    <= 4'h0;
      bpp_r       <= 6'h0;
      pixclk_r    <= 13'h0;
      cdclk_r     <= 13'h0;
      portclk_r   <= 13'h0;
      link_r      <= 6'h0;
      state_r     <= S_IDLE;
      step_r      <= 3'h0;
      widx_r      <= 3'h0;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      err_r       <= 8'h0;
      rows_r      <= 12'h0;
      lim_link_r  <= 6'h0;
      lim_thru_r  <= 6'h0;
      lim_bj_r    <= 6'h0;
      lim_ram_r   <= 6'h0;
      max_bpp_r   <= 6'h0;
      div_start_r <= 1'b0;
      o_rdata     <= 32'h0;
      o_dev_addr  <= 8'h0;
      o_dev_wdata <= 32'h0;
      o_dev_wr    <= 1'b0;
    end
    else
    begin
      div_start_r <= 1'b0;
      o_dev_wr    <= 1'b0;
      o_rdata     <= 32'h0;
      if (i_wr && !busy_r)
      begin
        case (i_addr)
          `DSCJ_REG_CTRL:    ctrl_r    <= {i_wdata[11:1], 1'b0};
          `DSCJ_REG_HACT:    hact_r    <= i_wdata[15:0];
          `DSCJ_REG_VACT:    vact_r    <= i_wdata[15:0];
          `DSCJ_REG_SLICE_W: slice_w_r <= i_wdata[15:0];
          `DSCJ_REG_SLICE_H: slice_h_r <= i_wdata[15:0];
          `DSCJ_REG_OVERLAP: overlap_r <= i_wdata[15:0];
          `DSCJ_REG_SLICES:  slices_r  <= i_wdata[3:0];
          `DSCJ_REG_BPP:     bpp_r     <= i_wdata[5:0];
          `DSCJ_REG_PIXCLK:  pixclk_r  <= i_wdata[12:0];
          `DSCJ_REG_CDCLK:   cdclk_r   <= i_wdata[12:0];
          `DSCJ_REG_PORTCLK: portclk_r <= i_wdata[12:0];
          `DSCJ_REG_LINK:    link_r    <= i_wdata[5:0];
          default:           ctrl_r    <= ctrl_r;
        endcase
      end
      if (i_rd)
      begin
        case (i_addr)
          `DSCJ_REG_CTRL:    o_rdata <= {20'h0, ctrl_r};
          `DSCJ_REG_HACT:    o_rdata <= {16'h0, hact_r};
          `DSCJ_REG_VACT:    o_rdata <= {16'h0, vact_r};
          `DSCJ_REG_SLICE_W: o_rdata <= {16'h0, slice_w_r};
          `DSCJ_REG_SLICE_H: o_rdata <= {16'h0, slice_h_r};
          `DSCJ_REG_OVERLAP: o_rdata <= {16'h0, overlap_r};
          `DSCJ_REG_SLICES:  o_rdata <= {28'h0, slices_r};
          `DSCJ_REG_BPP:     o_rdata <= {26'h0, bpp_r};
          `DSCJ_REG_PIXCLK:  o_rdata <= {19'h0, pixclk_r};
          `DSCJ_REG_CDCLK:   o_rdata <= {19'h0, cdclk_r};
          `DSCJ_REG_PORTCLK: o_rdata <= {19'h0, portclk_r};
          `DSCJ_REG_LINK:    o_rdata <= {26'h0, link_r};
          `DSCJ_REG_STATUS:  o_rdata <= {2'h0, busy_r, done_r, rows_r, 2'h0, max_bpp_r, err_r};
          default:           o_rdata <= 32'h0;
        endcase
      end
      case (state_r)
        S_IDLE:
        begin
          if (i_wr && !busy_r && i_addr == `DSCJ_REG_CTRL && i_wdata[`DSCJ_CTRL_GO])
          begin
            busy_r  <= 1'b1;
            done_r  <= 1'b0;
            err_r   <= 8'h0;
            step_r  <= 3'h0;
            state_r <= S_GO;
          end
        end
        S_GO:
        begin
          if (step_r == 3'h0)
            err_r <= err_nxt;
          div_start_r <= 1'b1;
          state_r     <= S_WAIT;
        end
        S_WAIT:
        begin
          if (div_done)
          begin
            case (step_r)
              // width must divide by slice width
              3'h0: if (div_rem != 48'h0 || slice_w_r == 16'h0) err_r[2] <= 1'b1;
              3'h1:
              begin
                if (div_rem != 48'h0 || div_quot == 48'h0 || div_quot > {32'h0, `DSCJ_MAX_ROWS})
                  err_r[3] <= 1'b1;
                rows_r <= div_quot[11:0];
              end
              3'h2: lim_link_r <= sat6(div_quot);
              3'h3: lim_thru_r <= sat6(div_quot);
              3'h4: lim_bj_r   <= sat6(div_quot);
              3'h5: lim_ram_r  <= sat6(div_quot);
              default: lim_ram_r <= lim_ram_r;
            endcase
            step_r  <= step_r + 3'h1;
            state_r <= (step_r == 3'h5) ? S_EVAL : S_GO;
          end
        end
        S_EVAL:
        begin
          max_bpp_r <= lim_min;
          if (bpp_r < `DSCJ_BPP_MIN || bpp_r > lim_min || err_r != 8'h0)
          begin
            err_r[6] <= (bpp_r < `DSCJ_BPP_MIN || bpp_r > lim_min);
            busy_r   <= 1'b0;
            done_r   <= 1'b1;
            state_r  <= S_IDLE;
          end
          else
            state_r <= S_VB;
        end
        S_VB:
        begin
          // start right after blank ends so the burst lands before the next
          if (vb_prev_r && !vb_s2_r)
          begin
            widx_r  <= 3'h0;
            state_r <= S_WRITE;
          end
        end
        S_WRITE:
        begin
          o_dev_wr    <= 1'b1;
          o_dev_addr  <= dev_cur[39:32];
          o_dev_wdata <= dev_cur[31:0];
          widx_r      <= widx_r + 3'h1;
          if (widx_r == (split ? 3'h6 : 3'h3))
          begin
            busy_r  <= 1'b0;
            done_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  dscj_divider u_div
  (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_start  (div_start_r),
    .i_num    (div_num),
    .i_den    (div_den),
    .o_done   (div_done),
    .o_quot   (div_quot),
    .o_rem    (div_rem)
  );

endmodule

// *** hw/dscj_defs.vh ***
`ifndef DSCJ_DEFS_VH
`define DSCJ_DEFS_VH

// controller command registers (byte offsets)
`define DSCJ_REG_CTRL      8'h00
`define DSCJ_REG_HACT      8'h04
`define DSCJ_REG_VACT      8'h08
`define DSCJ_REG_SLICE_W   8'h0c
`define DSCJ_REG_SLICE_H   8'h10
`define DSCJ_REG_OVERLAP   8'h14
`define DSCJ_REG_SLICES    8'h18
`define DSCJ_REG_BPP       8'h1c
`define DSCJ_REG_PIXCLK    8'h20
`define DSCJ_REG_CDCLK     8'h24
`define DSCJ_REG_PORTCLK   8'h28
`define DSCJ_REG_LINK      8'h2c
`define DSCJ_REG_STATUS    8'h30

// control field positions
`define DSCJ_CTRL_GO       0
`define DSCJ_CTRL_SPLIT    1
`define DSCJ_CTRL_JOIN     2
`define DSCJ_CTRL_BIG      3
`define DSCJ_CTRL_COMP     4
`define DSCJ_CTRL_MULTI_SEG 5
`define DSCJ_CTRL_FEC      6
`define DSCJ_CTRL_PIPE     7
`define DSCJ_CTRL_SYNC     8
`define DSCJ_CTRL_MODE_LO  9
`define DSCJ_CTRL_RESET    12'h000

// link topology codes
`define DSCJ_MODE_SINGLE   2'h0
`define DSCJ_MODE_DUAL_IND 2'h1
`define DSCJ_MODE_DUAL     2'h2

// device side register offsets
`define DSCJ_DEV_SJ_CTL    8'h00
`define DSCJ_DEV_BR0       8'h10
`define DSCJ_DEV_BR1       8'h20
`define DSCJ_DEV_SLICES    8'h00
`define DSCJ_DEV_PIC       8'h04
`define DSCJ_DEV_PPS       8'h08

// limits
`define DSCJ_MAX_ROWS      16'h0fff
`define DSCJ_MAX_W_ONE     16'h1400
`define DSCJ_MAX_W_TWO     16'h2000
`define DSCJ_BPP_MIN       6'h08
`define DSCJ_BPP_MAX       6'h17
`define DSCJ_RAM_ONE       48'h0000_0000_1e00
`define DSCJ_RAM_TWO       48'h0000_0000_3c00
`define DSCJ_FEC_SCALE     48'h0000_000e_d5e5
`define DSCJ_ONE_SCALE     48'h0000_000f_4240
`define DSCJ_BJ_BITS       48'h0000_0000_0018
`define DSCJ_THRU_BITS     48'h0000_0000_0048
`define DSCJ_LANE_BITS     48'h0000_0000_0008
`define DSCJ_DIV_STEPS     6'h30

`endif

// *** hw/dscj_divider.v ***
`timescale 1ns/1ps
// restoring divider, one quotient bit per cycle
module dscj_divider
(
  // clock and reset
  input  wire        i_clock,
  input  wire        i_resetn,
  // request
  input  wire        i_start,
  input  wire [47:0] i_num,
  input  wire [47:0] i_den,
  // answer
  output reg         o_done,
  output reg  [47:0] o_quot,
  output reg  [47:0] o_rem
);
`include "dscj_defs.vh"

  reg  [47:0] den_r;
  reg  [5:0]  cnt_r;
  wire [47:0] trial;

  assign trial = {o_rem[46:0], o_quot[47]};

  // a zero divisor yields an all-ones quotient; only the row count step catches it as a range fault
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      den_r  <= 48'h0;
      cnt_r  <= 6'h0;
      o_done <= 1'b0;
      o_quot <= 48'h0;
      o_rem  <= 48'h0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        den_r  <= i_den;
        o_quot <= i_num;
        o_rem  <= 48'h0;
        cnt_r  <= `DSCJ_DIV_STEPS;
      end
      else if (cnt_r != 6'h0)
      begin
        cnt_r <= cnt_r - 6'h1;
        if (trial >= den_r)
        begin
          o_rem  <= trial - den_r;
          o_quot <= {o_quot[46:0], 1'b1};
        end
        else
        begin
          o_rem  <= trial;
          o_quot <= {o_quot[46:0], 1'b0};
        end
        if (cnt_r == 6'h1)
          o_done <= 1'b1;
      end
    end
  end

endmodule

// *** tb/dscj_ctrl_assertions.sv ***
`timescale 1ns/1ps
module dscj_ctrl_chk
(
  // clock and reset
  input wire        i_clock,
  input wire        i_resetn,
  // software port
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  // device pins
  input wire        i_vblank,
  input wire [7:0]  o_dev_addr,
  input wire [31:0] o_dev_wdata,
  input wire        o_dev_wr
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  wire ctl_w = o_dev_wr && o_dev_addr == 8'h00;
  wire sl_w  = o_dev_wr && (o_dev_addr == 8'h10 || o_dev_addr == 8'h20);
  wire pps_w = o_dev_wr && (o_dev_addr == 8'h18 || o_dev_addr == 8'h28);
  sequence s_branch0;
    o_dev_wr && o_dev_addr == 8'h10 ##1 o_dev_wr && o_dev_addr == 8'h14 ##1 o_dev_wr && o_dev_addr == 8'h18;
  endsequence
  sequence s_branch1;
    o_dev_wr && o_dev_addr == 8'h20 ##1 o_dev_wr && o_dev_addr == 8'h24 ##1 o_dev_wr && o_dev_addr == 8'h28;
  endsequence
  burst_order_a: assert property ($rose(o_dev_wr) |-> o_dev_addr == 8'h00 ##1 s_branch0)
    else $error("device burst out of order");
  burst_len_a: assert property (o_dev_wr [*7] |=> !o_dev_wr)
    else $error("device burst too long");
  lower_branch_a: assert property ($rose(o_dev_wr) && o_dev_wdata[0] |-> ##4 s_branch1)
    else $error("split burst lacks lower branch");
  single_branch_a: assert property ($rose(o_dev_wr) && !o_dev_wdata[0] |-> ##4 !o_dev_wr)
    else $error("unsplit burst too long");
  upper_left_a: assert property (ctl_w |-> o_dev_wdata[5])
    else $error("joined output not on left");
  big_combo_a: assert property (ctl_w && o_dev_wdata[2] |-> o_dev_wdata[1] && o_dev_wdata[3])
    else $error("big joiner without join or compression");
  join_split_a: assert property (ctl_w && o_dev_wdata[1] |-> o_dev_wdata[0])
    else $error("join without split");
  dual_link_a: assert property (ctl_w && o_dev_wdata[7:6] == 2'h2 |-> o_dev_wdata[0] && !o_dev_wdata[1]
    && o_dev_wdata[8])
    else $error("dual link control wrong");
  branch_slices_a: assert property (sl_w |-> o_dev_wdata[3:0] == 4'h1 || o_dev_wdata[3:0] == 4'h2)
    else $error("branch slice count out of range");
  slice_rows_a: assert property (sl_w |-> o_dev_wdata[27:16] != 12'h000)
    else $error("slice rows zero");
  pps_bpp_a: assert property (pps_w |-> o_dev_wdata[21:16] >= 6'h08 && o_dev_wdata[21:16] <= 6'h17)
    else $error("bpp out of range");
endmodule

// *** tb/dscj_dev_model.sv ***
`timescale 1ns/1ps
module dscj_dev_model
(
  // clock and reset
  input  wire        i_clock,
  input  wire        i_resetn,
  // register writes
  input  wire [7:0]  i_dev_addr,
  input  wire [31:0] i_dev_wdata,
  input  wire        i_dev_wr,
  // frame timing
  output reg         o_vblank
);
  localparam integer JOIN_RAM_ONE = 7680;
  localparam integer JOIN_RAM_TWO = 15360;
  reg [31:0] shadow_r [0:63];
  reg [31:0] live_r   [0:63];
  reg [7:0]  line_r;
  integer    j;
  // short frame keeps the run brief; real frames are far longer
  always @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      line_r   <= 8'h00;
      o_vblank <= 1'b0;
      for (j = 0; j < 64; j = j + 1)
      begin
        shadow_r[j] <= 32'h0;
        live_r[j]   <= 32'h0;
      end
    end
    else
    begin
      line_r   <= (line_r == 8'd219) ? 8'h00 : line_r + 8'h01;
      o_vblank <= line_r < 8'd20;
      if (i_dev_wr)
        shadow_r[i_dev_addr[7:2]] <= i_dev_wdata;
      // all settings go live together at blank start
      if (line_r == 8'd0)
        for (j = 0; j < 64; j = j + 1)
          live_r[j] <= shadow_r[j];
    end
  end
endmodule

// *** tb/tb_dscj_ctrl.sv ***
`timescale 1ns/1ps
`include "dscj_defs.vh"
module tb_dscj_ctrl;
  reg          i_clock = 1'b0;
  reg          i_resetn;
  reg  [7:0]   i_addr;
  reg  [31:0]  i_wdata;
  reg          i_wr;
  reg          i_rd;
  reg          rd_chk;
  reg          rd_d1;
  wire [31:0]  o_rdata;
  wire         vblank;
  wire [7:0]   o_dev_addr;
  wire [31:0]  o_dev_wdata;
  wire         o_dev_wr;
  integer      miscompares;
  integer      compares;
  integer      seed;
  integer      k;
  integer      n;
  reg  [31:0]  d;
  reg  [7:0]   ba;
  reg  [5:0]   bpp;
  reg  [63:0]  rq[$];
  reg  [71:0]  dq[$];
  reg  [35:0]  errs [0:2];

  dscj_ctrl dscj_ctrl_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vblank(vblank), .o_dev_addr(o_dev_addr),
    .o_dev_wdata(o_dev_wdata), .o_dev_wr(o_dev_wr));
  dscj_dev_model dscj_dev_model_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_dev_addr(o_dev_addr),
    .i_dev_wdata(o_dev_wdata), .i_dev_wr(o_dev_wr), .o_vblank(vblank));

  always #4 i_clock = ~i_clock;

  task cmp_rd(input [31:0] got, input [63:0] e);
  begin
    compares = compares + 1;
    if ((got & e[63:32]) !== (e[31:0] & e[63:32]))
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: read %h expected %h", $time, got, e[31:0]);
    end
  end
  endtask

  task cmp_dev(input [7:0] a, input [31:0] got, input [71:0] e);
  begin
    compares = compares + 1;
    if (a !== e[71:64] || (got & e[63:32]) !== (e[31:0] & e[63:32]))
    begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: device %h %h expected %h %h", $time, a, got, e[71:64], e[31:0]);
    end
  end
  endtask

  // watcher: results are taken where they stand
  always @(posedge i_clock)
  begin
    rd_d1 <= i_rd & rd_chk;
    if (rd_d1)
      cmp_rd(o_rdata, rq.pop_front());
    if (o_dev_wr === 1'b1)
      cmp_dev(o_dev_addr, o_dev_wdata, dq.size() ? dq.pop_front() : {8'hff, 64'h0});
  end

  task wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  end
  endtask

  task rd(input [7:0] a, input chk, input [63:0] e);
  begin
    if (chk)
      rq.push_back(e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    rd_chk <= chk;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    @(negedge i_clock);
    d = o_rdata;
  end
  endtask

  task cfg(input [31:0] ctl, input [15:0] vact, input [3:0] tot, input [5:0] b);
  begin
    wr(`DSCJ_REG_HACT, 32'd3840);
    wr(`DSCJ_REG_VACT, {16'h0, vact});
    wr(`DSCJ_REG_SLICE_W, 32'd3840 / tot);
    wr(`DSCJ_REG_SLICE_H, 32'd108);
    wr(`DSCJ_REG_OVERLAP, 32'h0);
    wr(`DSCJ_REG_SLICES, {28'h0, tot});
    wr(`DSCJ_REG_BPP, {26'h0, b});
    wr(`DSCJ_REG_PIXCLK, 32'd500);
    wr(`DSCJ_REG_CDCLK, 32'd336);
    wr(`DSCJ_REG_PORTCLK, 32'd810);
    wr(`DSCJ_REG_LINK, 32'h24);
    wr(`DSCJ_REG_CTRL, ctl | 32'h1);
    d = 32'h2000_0000;
    n = 0;
    while (d[29] !== 1'b0 && n < 400)
    begin
      rd(`DSCJ_REG_STATUS, 1'b0, 64'h0);
      n = n + 1;
    end
    if (n == 400)
      miscompares = miscompares + 1;
  end
  endtask

  task good(input [31:0] ctl, input [3:0] tot, input [31:0] ectl, input [5:0] emax);
  begin
    bpp = 6'h08 + ($random(seed) & 6'h07);
    dq.push_back({8'h00, 32'h1ef, ectl});
    // one branch unless split; slices and width shared between branches
    for (k = 0; k < (ctl[1] ? 2 : 1); k = k + 1)
    begin
      ba = (k == 0) ? 8'h10 : 8'h20;
      dq.push_back({ba, 32'hffff_ffff, 4'h0, 12'd20, 12'h0, (ctl[1] ? tot >> 1 : tot)});
      dq.push_back({ba + 8'h04, 32'hffff_ffff, 16'd2160, (ctl[1] ? 16'd1920 : 16'd3840)});
      dq.push_back({ba + 8'h08, 32'hffff_ffff, 10'h0, bpp, 16'd3840});
    end
    cfg(ctl, 16'd2160, tot, bpp);
    rd(`DSCJ_REG_STATUS, 1'b1, {32'hffff_ffff, 3'h0, 1'b1, 12'd20, 2'h0, emax, 8'h00});
    $display("test done: ctl %h", ctl);
  end
  endtask

  task finish_test;
  begin
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  initial
  begin
    #400000;
    miscompares = miscompares + 1;
    finish_test;
  end

  initial
  begin
    i_resetn = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    rd_chk = 1'b0;
    miscompares = 0;
    compares = 0;
    seed = 32'h120a2715;
    // ctl, vact, error bit
    errs[0] = {12'h01d, 16'd2160, 8'h01};
    errs[1] = {12'h01b, 16'd2160, 8'h02};
    errs[2] = {12'h017, 16'd2161, 8'h08};
    repeat (4) @(posedge i_clock);
    i_resetn <= 1'b1;
    // single link, split plus join plus compress
    good(32'h016, 4'h4, 32'h2b, 6'd16);
    // dual link from the first pipe with port sync
    good(32'h512, 4'h2, 32'h1a9, 6'd16);
    // one branch only, error correction on
    good(32'h050, 4'h2, 32'h28, 6'd16);
    // two pipes joined, independent links, limit capped at 23
    good(32'h21e, 4'h4, 32'h6f, 6'd23);
    // bad settings must flag and write nothing
    for (n = 0; n < 3; n = n + 1)
    begin
      k = n;
      cfg({20'h0, errs[k][35:24]}, errs[k][23:8], (k == 0) ? 4'h3 : 4'h4, 6'h0c);
      rd(`DSCJ_REG_STATUS, 1'b1, {24'h0, errs[k][7:0], 24'h0, errs[k][7:0]});
      repeat (300) @(posedge i_clock);
      n = k;
      $display("test done: error case %0d", k);
    end
    // unmapped places hold nothing
    for (n = 0; n < 4; n = n + 1)
    begin
      ba = 8'h40 | ($random(seed) & 8'hbc);
      wr(ba, $random(seed));
      rd(ba, 1'b1, {32'hffff_ffff, 32'h0});
    end
    $display("test done: unmapped");
    finish_test;
  end
endmodule

bind dscj_ctrl dscj_ctrl_chk dscj_ctrl_chk_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_vblank(i_vblank),
  .o_dev_addr(o_dev_addr), .o_dev_wdata(o_dev_wdata), .o_dev_wr(o_dev_wr));
